// [hdl/uart_regs_pkg.sv]
// Shared offsets, bit positions, masks and reset values for the dual-channel register bank.
package uart_regs_pkg;

    // register offsets, standard bank
    localparam logic [2:0] OFS_HOLD = 3'h0;
    localparam logic [2:0] OFS_IER  = 3'h1;
    localparam logic [2:0] OFS_ISR  = 3'h2;
    localparam logic [2:0] OFS_LCR  = 3'h3;
    localparam logic [2:0] OFS_MCR  = 3'h4;
    localparam logic [2:0] OFS_LSR  = 3'h5;
    localparam logic [2:0] OFS_MSR  = 3'h6;
    localparam logic [2:0] OFS_SPR  = 3'h7;
    // register offsets, divisor and enhanced banks
    localparam logic [2:0] OFS_DLL  = 3'h0;
    localparam logic [2:0] OFS_DLM  = 3'h1;
    localparam logic [2:0] OFS_TRG  = 3'h0;
    localparam logic [2:0] OFS_FEATURE_CONTROL = 3'h1;
    localparam logic [2:0] OFS_EFR  = 3'h2;

    // bank keys and bit positions
    localparam logic [7:0] LCR_ENH_KEY    = 8'hBF;
    localparam int         LCR_DIV_BIT    = 7;
    localparam int         EFR_ENH_BIT    = 4;
    localparam int         FEATURE_CONTROL_SWAP_BIT  = 6;
    localparam int         FEATURE_CONTROL_IRINV_BIT = 2;
    localparam int         MCR_LOOP_BIT   = 4;
    localparam int         MCR_IR_BIT     = 6;
    localparam int         FCR_EN_BIT     = 0;
    localparam int         IER_TX_BIT     = 1;
    localparam int         LSR_THRE_BIT   = 5;
    localparam int         XCHAR_SEL_BIT  = 2;

    // extended and reserved masks
    localparam logic [7:0] IER_EXT_MASK  = 8'hF0;
    localparam logic [7:0] MCR_EXT_MASK  = 8'hE0;
    localparam logic [7:0] FCR_EXT_MASK  = 8'h30;
    localparam logic [7:0] ISR_EXT_MASK  = 8'h30;
    localparam logic [7:0] ENHANCED_MODE_SELECT_USE_MASK = 8'h33;

    // interrupt status codes, bits 5:0
    localparam logic [5:0] ISR_NONE = 6'h01;
    localparam logic [5:0] ISR_LSR  = 6'h06;
    localparam logic [5:0] ISR_RX   = 6'h04;
    localparam logic [5:0] ISR_TX   = 6'h02;
    localparam logic [5:0] ISR_MSR  = 6'h00;

    // reset and identity values (identity values are arbitrary)
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [7:0] DIV_ZERO      = 8'h00;
    localparam logic [7:0] REVISION_CODE = 8'h01;
    localparam logic [7:0] DEVICE_ID     = 8'h5A;

    typedef enum logic [1:0] {BANK_STD, BANK_DIV, BANK_ENH} bank_e;

endpackage : uart_regs_pkg

// [hdl/uart_channel_register_map.sv]
// Dual-channel host register bank with interrupt reporting and serial path muxing.
// Summary of operation
// - extended bits work only while enhanced-function bit 4 is set
// - offset 0 standard bank: read gives receive holding, write loads transmit holding
// - interrupt-enable bits mask receive, transmit, line and modem sources from irq
// - the highest-priority unmasked pending source is reported in read-only interrupt status
// - each channel owns its registers; three address bits plus per-channel select
// - modem-control bit 6, with bit 4 clear, routes serial path through infrared coder; tx idles low
// - modem-control bit 4 loops transmit to receive and holds tx pin at mark
`timescale 1ns/1ps

module uart_channel_register_map
    import uart_regs_pkg::*;
(
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            arst_n,
    // host bus
    input  wire logic [2:0]      addr,
    input  wire logic            channel_a_select_n,
    input  wire logic            channel_b_select_n,
    input  wire logic            rd_strobe_n,
    input  wire logic            wr_strobe_n,
    input  wire logic [7:0]      wr_data,
    output logic      [7:0]      rd_data,
    // receiver side, per channel
    input  wire logic [1:0]      rx_push,
    input  wire logic [1:0][7:0] rx_char,
    input  wire logic [1:0][7:1] line_status,
    input  wire logic [1:0][7:0] fifo_count,
    output logic      [1:0]      rx_pop,
    // transmitter and configuration, per channel
    output logic      [1:0][7:0] tx_data,
    output logic      [1:0]      tx_load,
    output logic      [1:0][7:0] line_ctrl,
    output logic      [1:0][7:0] modem_ctrl,
    output logic      [1:0][7:0] fifo_ctrl,
    output logic      [1:0]      fifo_ctrl_load,
    output logic      [1:0][7:0] divisor_low,
    output logic      [1:0][7:0] divisor_high,
    // modem inputs: bit 0 cts, 1 dsr, 2 ri, 3 cd
    input  wire logic [1:0][3:0] modem_in,
    // serial path
    input  wire logic [1:0]      tx_shift_out,
    input  wire logic [1:0]      rx_pin,
    output logic      [1:0]      tx_pin,
    output logic      [1:0]      rx_shift_in,
    // interrupt, active high
    output logic      [1:0]      irq
);

    typedef struct packed {
        logic [1:0][7:0]      irq_enable_mask;
        logic [1:0][7:0]      line_control;
        logic [1:0][7:0]      modem_control;
        logic [1:0][7:0]      dll;
        logic [1:0][7:0]      baud_divisor_high;
        logic [1:0][7:0]      scratch_pad;
        logic [1:0][7:0]      fifo_control;
        logic [1:0][7:0]      fifo_trigger_levels;
        logic [1:0][7:0]      feature_control;
        logic [1:0][7:0]      enhanced_function;
        logic [1:0][7:0]      enhanced_mode_select;
        logic [1:0][7:0]      rx_hold;
        logic [1:0][7:0]      tx_data;
        logic [1:0][3:0][7:0] xchar;
        logic [1:0][3:0]      msr_delta;
        logic [1:0][3:0]      modem_q;
        logic [1:0]           rx_full;
        logic [1:0]           tx_irq;
        logic [1:0]           thre_q;
        logic [1:0]           tx_load;
        logic [1:0]           rx_pop;
        logic [1:0]           fcr_load;
        logic [1:0]           tx_pin;
        logic [1:0]           rx_in;
        logic [1:0]           irq;
        logic [7:0]           rd_data;
        logic                 rd_q;
        logic                 wr_q;
    } state_s;

    state_s     st;
    state_s     next_st;
    logic [1:0] sel;
    logic       rd_go;
    logic       wr_go;
    bank_e      bk;
    logic       enh;
    logic       dz;
    logic [3:0] pend;
    logic [5:0] code;
    logic [7:0] rv;
    logic       clr_tx;

    // bank chosen by the line-control value
    function automatic bank_e bank_of(input logic [7:0] l);
        if (l == LCR_ENH_KEY) begin
            return BANK_ENH;
        end
        return l[LCR_DIV_BIT] ? BANK_DIV : BANK_STD;
    endfunction : bank_of

    // clears extended bits while the enhanced bit is off
    function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m, input logic on);
        return on ? v : (v & ~m);
    endfunction : gate

    // priority: line, receive, transmit, modem; bits follow ier order
    function automatic logic [5:0] isr_code(input logic [3:0] p);
        if (p[2]) begin
            return ISR_LSR;
        end
        if (p[0]) begin
            return ISR_RX;
        end
        if (p[1]) begin
            return ISR_TX;
        end
        return p[3] ? ISR_MSR : ISR_NONE;
    endfunction : isr_code

    // strobes act once, on their first low cycle
    assign sel   = {~channel_b_select_n, ~channel_a_select_n};
    assign rd_go = ~rd_strobe_n & ~st.rd_q;
    assign wr_go = ~wr_strobe_n & ~st.wr_q;

    // next state for both channels
    always_comb begin
        next_st          = st;
        bk               = BANK_STD;
        enh              = 1'b0;
        dz               = 1'b0;
        pend             = '0;
        code             = ISR_NONE;
        rv               = RST_REG;
        clr_tx           = 1'b0;
        next_st.rd_q     = ~rd_strobe_n;
        next_st.wr_q     = ~wr_strobe_n;
        next_st.tx_load  = '0;
        next_st.rx_pop   = '0;
        next_st.fcr_load = '0;
        for (int c = 0; c < 2; c++) begin
            bk     = bank_of(st.line_control[c]);
            enh    = st.enhanced_function[c][EFR_ENH_BIT];
            dz     = (st.dll[c] == DIV_ZERO) && (st.baud_divisor_high[c] == DIV_ZERO);
            clr_tx = 1'b0;
            // pending sources gated by their enables
            pend = {|st.msr_delta[c], |line_status[c][4:1], st.tx_irq[c], st.rx_full[c]} & st.irq_enable_mask[c][3:0];
            code = isr_code(pend);
            next_st.irq[c] = |pend;

            // read decode; each channel answers only its own select
            rv = RST_REG;
            case (bk)
                BANK_STD: begin
                    case (addr)
                        OFS_HOLD: rv = st.rx_hold[c];
                        OFS_IER:  rv = st.irq_enable_mask[c];
                        OFS_ISR:  rv = gate({{2{st.fifo_control[c][FCR_EN_BIT]}}, code}, ISR_EXT_MASK, enh);
                        OFS_LCR:  rv = st.line_control[c];
                        OFS_MCR:  rv = st.modem_control[c];
                        OFS_LSR:  rv = {line_status[c], st.rx_full[c]};
                        OFS_MSR:  rv = {modem_in[c], st.msr_delta[c]};
                        default:  rv = st.feature_control[c][FEATURE_CONTROL_SWAP_BIT] ? fifo_count[c] : st.scratch_pad[c];
                    endcase
                end
                BANK_DIV: begin
                    case (addr)
                        OFS_DLL: rv = dz ? REVISION_CODE : st.dll[c];
                        OFS_DLM: rv = dz ? DEVICE_ID : st.baud_divisor_high[c];
                        OFS_LCR: rv = st.line_control[c];
                        default: rv = RST_REG;
                    endcase
                end
                default: begin
                    case (addr)
                        OFS_TRG:  rv = fifo_count[c];
                        OFS_FEATURE_CONTROL: rv = st.feature_control[c];
                        OFS_EFR:  rv = st.enhanced_function[c];
                        OFS_LCR:  rv = st.line_control[c];
                        default:  rv = st.xchar[c][addr[1:0]];
                    endcase
                end
            endcase

            // read side effects
            if (rd_go && sel[c]) begin
                next_st.rd_data = rv;
                if (bk == BANK_STD && addr == OFS_HOLD) begin
                    next_st.rx_full[c] = 1'b0;
                    next_st.rx_pop[c]  = 1'b1;
                end
                if (bk == BANK_STD && addr == OFS_ISR && code == ISR_TX) begin
                    clr_tx = 1'b1;
                end
                if (bk == BANK_STD && addr == OFS_MSR) begin
                    next_st.msr_delta[c] = '0;
                end
            end

            // write decode; line and modem status offsets ignore writes, offset 2 loads fifo control
            if (wr_go && sel[c]) begin
                case (bk)
                    BANK_STD: begin
                        case (addr)
                            OFS_HOLD: begin
                                next_st.tx_data[c] = wr_data;
                                next_st.tx_load[c] = 1'b1;
                                clr_tx             = 1'b1;
                            end
                            OFS_IER: next_st.irq_enable_mask[c] = wr_data;
                            OFS_ISR: begin
                                next_st.fifo_control[c]      = wr_data;
                                next_st.fcr_load[c] = 1'b1;
                            end
                            OFS_LCR: next_st.line_control[c] = wr_data;
                            OFS_MCR: next_st.modem_control[c] = wr_data;
                            OFS_SPR: begin
                                if (st.feature_control[c][FEATURE_CONTROL_SWAP_BIT]) begin
                                    next_st.enhanced_mode_select[c] = wr_data & ENHANCED_MODE_SELECT_USE_MASK;
                                end else begin
                                    next_st.scratch_pad[c] = wr_data;
                                end
                            end
                            default: ;
                        endcase
                    end
                    BANK_DIV: begin
                        case (addr)
                            OFS_DLL: next_st.dll[c] = wr_data;
                            OFS_DLM: next_st.baud_divisor_high[c] = wr_data;
                            OFS_LCR: next_st.line_control[c] = wr_data;
                            default: ;
                        endcase
                    end
                    default: begin
                        if (addr[XCHAR_SEL_BIT]) begin
                            next_st.xchar[c][addr[1:0]] = wr_data;
                        end else begin
                            case (addr)
                                OFS_TRG:  next_st.fifo_trigger_levels[c]  = wr_data;
                                OFS_FEATURE_CONTROL: next_st.feature_control[c] = wr_data;
                                OFS_EFR:  next_st.enhanced_function[c]  = wr_data;
                                OFS_LCR:  next_st.line_control[c]  = wr_data;
                                default: ;
                            endcase
                        end
                    end
                endcase
            end

            // extended bits follow the enhanced bit, on write and later
            next_st.irq_enable_mask[c] = gate(next_st.irq_enable_mask[c], IER_EXT_MASK, next_st.enhanced_function[c][EFR_ENH_BIT]);
            next_st.modem_control[c] = gate(next_st.modem_control[c], MCR_EXT_MASK, next_st.enhanced_function[c][EFR_ENH_BIT]);
            next_st.fifo_control[c] = gate(next_st.fifo_control[c], FCR_EXT_MASK, next_st.enhanced_function[c][EFR_ENH_BIT]);

            // transmit-empty event: set wins over a same-cycle clear
            next_st.thre_q[c] = line_status[c][LSR_THRE_BIT];
            if (clr_tx) begin
                next_st.tx_irq[c] = 1'b0;
            end
            if ((line_status[c][LSR_THRE_BIT] && !st.thre_q[c]) ||
                (line_status[c][LSR_THRE_BIT] && next_st.irq_enable_mask[c][IER_TX_BIT] && !st.irq_enable_mask[c][IER_TX_BIT])) begin
                next_st.tx_irq[c] = 1'b1;
            end

            // modem deltas: a change in the clearing cycle is kept
            next_st.modem_q[c]   = modem_in[c];
            next_st.msr_delta[c] = next_st.msr_delta[c] | (modem_in[c] ^ st.modem_q[c]);

            // received character, set wins over the pop
            if (rx_push[c]) begin
                next_st.rx_hold[c] = rx_char[c];
                next_st.rx_full[c] = 1'b1;
            end

            // serial path; the ir coder here is a level inversion, not a pulse shaper
            if (st.modem_control[c][MCR_LOOP_BIT]) begin
                next_st.tx_pin[c] = 1'b1;
                next_st.rx_in[c]  = tx_shift_out[c];
            end else if (st.modem_control[c][MCR_IR_BIT]) begin
                next_st.tx_pin[c] = ~tx_shift_out[c];
                next_st.rx_in[c]  = ~rx_pin[c] ^ st.feature_control[c][FEATURE_CONTROL_IRINV_BIT];
            end else begin
                next_st.tx_pin[c] = tx_shift_out[c];
                next_st.rx_in[c]  = rx_pin[c];
            end
        end
    end

    // single state register; tx pin rests at mark out of reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0;
            st.tx_pin <= '1;
        end else begin
            st <= next_st;
        end
    end

    // every output is a state bit
    assign rd_data        = st.rd_data;
    assign rx_pop         = st.rx_pop;
    assign tx_data        = st.tx_data;
    assign tx_load        = st.tx_load;
    assign line_ctrl      = st.line_control;
    assign modem_ctrl     = st.modem_control;
    assign fifo_ctrl      = st.fifo_control;
    assign fifo_ctrl_load = st.fcr_load;
    assign divisor_low    = st.dll;
    assign divisor_high   = st.baud_divisor_high;
    assign tx_pin         = st.tx_pin;
    assign rx_shift_in    = st.rx_in;
    assign irq            = st.irq;

    // checks on channel a
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence hold_read_s;
        rd_go && sel == 2'h1 && addr == OFS_HOLD && bank_of(st.line_control[0]) == BANK_STD;
    endsequence
    sequence hold_write_s;
        wr_go && sel == 2'h1 && addr == OFS_HOLD && bank_of(st.line_control[0]) == BANK_STD;
    endsequence

    ext_bits_gated_a: assert property (!st.enhanced_function[0][EFR_ENH_BIT] |-> st.irq_enable_mask[0][7:4] == 4'h0 && st.modem_control[0][7:5] == 3'h0)
        else $error("extended bits set while enhanced mode is off");
    hold_read_a: assert property (hold_read_s |=> rd_data == $past(st.rx_hold[0]) && rx_pop[0] ##1 !rx_pop[0])
        else $error("receive holding read wrong");
    hold_write_a: assert property (hold_write_s |=> tx_load[0] && tx_data[0] == $past(wr_data) ##1 !tx_load[0])
        else $error("transmit holding write wrong");
    irq_mask_a: assert property (st.irq_enable_mask[0][3:0] == 4'h0 |=> !irq[0])
        else $error("masked source raised irq");
    irq_rx_a: assert property (st.irq_enable_mask[0][0] && st.rx_full[0] |=> irq[0])
        else $error("enabled receive source did not raise irq");
    isr_none_a: assert property (rd_go && sel == 2'h1 && addr == OFS_ISR && bank_of(st.line_control[0]) == BANK_STD
                                 && st.irq_enable_mask[0][3:0] == 4'h0 |=> rd_data[5:0] == ISR_NONE)
        else $error("status shows a masked source");
    chan_sel_a: assert property (wr_go && sel == 2'h2 |=> $stable(st.irq_enable_mask[0]) && $stable(st.line_control[0]))
        else $error("channel b write touched channel a");
    ir_idle_a: assert property (st.modem_control[0][MCR_IR_BIT] && !st.modem_control[0][MCR_LOOP_BIT] && tx_shift_out[0] |=> !tx_pin[0])
        else $error("infrared tx does not idle low");
    loop_mark_a: assert property (st.modem_control[0][MCR_LOOP_BIT] |=> tx_pin[0] && rx_shift_in[0] == $past(tx_shift_out[0]))
        else $error("loopback routing wrong");
    rsvd_zero_a: assert property (rd_go && sel == 2'h1 && bank_of(st.line_control[0]) == BANK_DIV && addr[2] |=> rd_data == 8'h00)
        else $error("unmapped divisor bank read not zero");

endmodule : uart_channel_register_map

// [dv/host_bus_model.sv]
// Host processor model that drives the parallel register bus of the dual channel bank.
`timescale 1ns/1ps

module host_bus_model (
    // clock
    input  wire logic       sys_clk,
    // host bus
    output logic      [2:0] addr,
    output logic            channel_a_select_n,
    output logic            channel_b_select_n,
    output logic            rd_strobe_n,
    output logic            wr_strobe_n,
    output logic      [7:0] wr_data,
    input  wire logic [7:0] rd_data
);
    // bus idle from time zero
    initial begin
        addr               = 3'h0;
        channel_a_select_n = 1'b1;
        channel_b_select_n = 1'b1;
        rd_strobe_n        = 1'b1;
        wr_strobe_n        = 1'b1;
        wr_data            = 8'h00;
    end

    // one access: ch 0 is channel A; strobe stays high a full edge between accesses
    task automatic access(input logic ch, input logic [2:0] ofs, input logic wr, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge sys_clk);
        addr               = ofs;
        channel_a_select_n = ch;
        channel_b_select_n = ~ch;
        wr_data            = d;
        rd_strobe_n        = wr;
        wr_strobe_n        = ~wr;
        @(posedge sys_clk);
        @(negedge sys_clk);
        // released lines flip so a stale value can never pass for a fresh one
        rd_strobe_n        = 1'b1;
        wr_strobe_n        = 1'b1;
        channel_a_select_n = 1'b1;
        channel_b_select_n = 1'b1;
        addr               = ~addr;
        wr_data            = ~wr_data;
        @(posedge sys_clk);
        @(negedge sys_clk);
        q = rd_data;
    endtask : access
endmodule : host_bus_model

// [dv/test_uart_channel_register_map.sv]
// Self-checking bench for the dual-channel register bank.
`timescale 1ns/1ps

module test_uart_channel_register_map
    import uart_regs_pkg::*;
;
    logic            sys_clk = 1'b0;
    logic            arst_n;
    logic [2:0]      addr;
    logic            channel_a_select_n;
    logic            channel_b_select_n;
    logic            rd_strobe_n;
    logic            wr_strobe_n;
    logic [7:0]      wr_data;
    logic [7:0]      rd_data;
    logic [1:0]      rx_push;
    logic [1:0][7:0] rx_char;
    logic [1:0][7:1] line_status;
    logic [1:0][7:0] fifo_count;
    logic [1:0]      rx_pop;
    logic [1:0][7:0] tx_data;
    logic [1:0]      tx_load;
    logic [1:0][7:0] line_ctrl;
    logic [1:0][7:0] modem_ctrl;
    logic [1:0][7:0] fifo_ctrl;
    logic [1:0]      fifo_ctrl_load;
    logic [1:0][7:0] divisor_low;
    logic [1:0][7:0] divisor_high;
    logic [1:0][3:0] modem_in;
    logic [1:0]      tx_shift_out;
    logic [1:0]      rx_pin;
    logic [1:0]      tx_pin;
    logic [1:0]      rx_shift_in;
    logic [1:0]      irq;
    int              error_cnt = 0;
    int              cmp_count = 0;
    int              tx_load_cnt = 0;
    int              rx_pop_cnt  = 0;
    int              fifo_ld_cnt = 0;

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    // one-cycle pulses counted where settled, so a check after the access still sees them
    always @(negedge sys_clk) begin
        if (tx_load[0]) begin
            tx_load_cnt++;
        end
        if (rx_pop[0]) begin
            rx_pop_cnt++;
        end
        if (fifo_ctrl_load[0]) begin
            fifo_ld_cnt++;
        end
    end

    host_bus_model u_host (.sys_clk, .addr, .channel_a_select_n, .channel_b_select_n, .rd_strobe_n,
                           .wr_strobe_n, .wr_data, .rd_data);

    uart_channel_register_map u_dut (.sys_clk, .arst_n, .addr, .channel_a_select_n, .channel_b_select_n,
        .rd_strobe_n, .wr_strobe_n, .wr_data, .rd_data, .rx_push, .rx_char, .line_status, .fifo_count,
        .rx_pop, .tx_data, .tx_load, .line_ctrl, .modem_ctrl, .fifo_ctrl, .fifo_ctrl_load, .divisor_low,
        .divisor_high, .modem_in, .tx_shift_out, .rx_pin, .tx_pin, .rx_shift_in, .irq);

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_cnt(input string nm, input int e, input int g);
        cmp_count++;
        if (g != e) begin
            error_cnt++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cnt

    task automatic wr(input logic c, input logic [2:0] o, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(c, o, 1'b1, d, q);
    endtask : wr

    // read and compare in one call
    task automatic rd(input logic c, input logic [2:0] o, input logic [7:0] e, input string nm);
        logic [7:0] q;
        u_host.access(c, o, 1'b0, 8'h00, q);
        chk_byte(nm, e, q);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // one-cycle receive push on channel A, then wait out the two-edge irq latency
    task automatic push_a(input logic [7:0] ch);
        rx_char[0] = ch;
        rx_push    = 2'b01;
        cyc(1);
        rx_push    = 2'b00;
        cyc(2);
    endtask : push_a

    // enhanced-function bit 4 set or cleared through the enhanced bank
    task automatic enh_a(input logic [7:0] v);
        wr(0, OFS_LCR, LCR_ENH_KEY);
        wr(0, OFS_EFR, v);
        wr(0, OFS_LCR, 8'h00);
    endtask : enh_a

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // hang guard: an exhausted bound counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        arst_n       = 1'b0;
        rx_push      = 2'b00;
        rx_char      = '0;
        line_status  = {7'h30, 7'h30};
        fifo_count   = {8'h07, 8'h03};
        modem_in     = '0;
        tx_shift_out = 2'b11;
        rx_pin       = 2'b11;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;

        rd(0, OFS_IER, 8'h00, "ier reset");
        rd(0, OFS_ISR, {2'b00, ISR_NONE}, "isr reset");
        chk_byte("tx pin idle", 8'h03, {6'h00, tx_pin});
        $display("test reset done");

        wr(0, OFS_HOLD, 8'hA5);
        chk_byte("tx data a", 8'hA5, tx_data[0]);
        chk_cnt("tx load", 1, tx_load_cnt);
        cyc(1);
        chk_byte("tx load end", 8'h00, {6'h00, tx_load});
        chk_cnt("tx load once", 1, tx_load_cnt);
        push_a(8'h3C);
        rd(0, OFS_HOLD, 8'h3C, "rx holding");
        chk_cnt("rx pop", 1, rx_pop_cnt);
        chk_byte("tx after read", 8'hA5, tx_data[0]);
        chk_byte("tx data b", 8'h00, tx_data[1]);
        $display("test holding done");

        wr(0, OFS_SPR, 8'h11);
        wr(1, OFS_SPR, 8'h22);
        rd(0, OFS_SPR, 8'h11, "scratch a");
        rd(1, OFS_SPR, 8'h22, "scratch b");
        $display("test channels done");

        // each source unmasked in turn; only the receive source is also checked while masked
        wr(0, OFS_IER, 8'h01);
        push_a(8'h5E);
        chk_bit("irq rx", 1'b1, irq[0]);
        rd(0, OFS_ISR, {2'b00, ISR_RX}, "isr rx");
        rd(0, OFS_HOLD, 8'h5E, "rx holding 2");
        cyc(1);
        chk_bit("irq rx clear", 1'b0, irq[0]);
        wr(0, OFS_IER, 8'h00);
        push_a(8'h61);
        chk_bit("irq masked", 1'b0, irq[0]);
        rd(0, OFS_HOLD, 8'h61, "rx holding 3");
        wr(0, OFS_IER, 8'h04);
        line_status[0] = 7'h31;
        cyc(2);
        chk_bit("irq line", 1'b1, irq[0]);
        rd(0, OFS_ISR, {2'b00, ISR_LSR}, "isr line");
        line_status[0] = 7'h30;
        cyc(2);
        chk_bit("irq line clear", 1'b0, irq[0]);
        wr(0, OFS_IER, 8'h02);
        cyc(1);
        chk_bit("irq tx", 1'b1, irq[0]);
        rd(0, OFS_ISR, {2'b00, ISR_TX}, "isr tx");
        cyc(1);
        chk_bit("irq tx clear", 1'b0, irq[0]);
        wr(0, OFS_IER, 8'h08);
        modem_in[0] = 4'h1;
        cyc(3);
        chk_bit("irq modem", 1'b1, irq[0]);
        rd(0, OFS_ISR, {2'b00, ISR_MSR}, "isr modem");
        rd(0, OFS_MSR, 8'h11, "modem status");
        cyc(1);
        chk_bit("irq modem clear", 1'b0, irq[0]);
        chk_bit("irq b quiet", 1'b0, irq[1]);
        $display("test interrupts done");

        wr(0, OFS_IER, 8'hF5);
        rd(0, OFS_IER, 8'h05, "ier ext off");
        enh_a(8'h10);
        rd(0, OFS_IER, 8'h05, "ier old ext");
        wr(0, OFS_IER, 8'hF0);
        rd(0, OFS_IER, 8'hF0, "ier ext on");
        wr(0, OFS_ISR, 8'h31);
        chk_byte("fifo ctrl ext", 8'h31, fifo_ctrl[0]);
        chk_cnt("fifo ctrl load", 1, fifo_ld_cnt);
        rd(0, OFS_ISR, {2'b11, ISR_NONE}, "isr fifo on");
        enh_a(8'h00);
        rd(0, OFS_IER, 8'h00, "ier ext gated");
        chk_byte("fifo ctrl gated", 8'h01, fifo_ctrl[0]);
        $display("test extended done");

        wr(0, OFS_MCR, 8'h10);
        tx_shift_out[0] = 1'b0;
        cyc(2);
        chk_bit("loop tx mark", 1'b1, tx_pin[0]);
        chk_bit("loop rx low", 1'b0, rx_shift_in[0]);
        tx_shift_out[0] = 1'b1;
        cyc(2);
        chk_bit("loop rx high", 1'b1, rx_shift_in[0]);
        enh_a(8'h10);
        wr(0, OFS_MCR, 8'h40);
        chk_byte("modem ctrl ir", 8'h40, modem_ctrl[0]);
        cyc(1);
        chk_bit("ir tx idle", 1'b0, tx_pin[0]);
        chk_bit("ir rx", 1'b0, rx_shift_in[0]);
        // feature control: swap the scratch location, invert the infrared input
        wr(0, OFS_LCR, LCR_ENH_KEY);
        wr(0, OFS_FEATURE_CONTROL, 8'h44);
        wr(0, 3'h4, 8'h9C);
        rd(0, 3'h4, 8'h9C, "flow char");
        rd(0, OFS_TRG, 8'h03, "level enhanced");
        wr(0, OFS_LCR, 8'h00);
        chk_bit("ir rx inverted", 1'b1, rx_shift_in[0]);
        rd(0, OFS_SPR, 8'h03, "level swapped");
        wr(0, OFS_MCR, 8'h00);
        cyc(1);
        chk_bit("straight tx", 1'b1, tx_pin[0]);
        $display("test serial done");

        wr(0, OFS_LCR, 8'h80);
        rd(0, OFS_DLL, REVISION_CODE, "revision");
        rd(0, OFS_DLM, DEVICE_ID, "device id");
        wr(0, OFS_DLL, 8'h34);
        chk_byte("divisor low", 8'h34, divisor_low[0]);
        rd(0, OFS_DLL, 8'h34, "divisor readback");
        wr(0, OFS_DLM, 8'h12);
        chk_byte("divisor high", 8'h12, divisor_high[0]);
        chk_byte("line ctrl", 8'h80, line_ctrl[0]);
        rd(0, 3'h5, 8'h00, "divisor reserved");
        $display("test divisor done");
        conclude();
    end
endmodule : test_uart_channel_register_map
